// ### hw/dpg_top.sv
// Contract
// - Period is a 32-bit count of update ticks, two or more.
// - High time is a 32-bit count of update ticks, one or more.
// - A 32-bit delay of update ticks precedes output after a trigger.
// - A 32-bit loop count repeats the period; zero repeats forever.
// - Modes: single sequence, repeated per trigger, or gated output.
// - Trigger source: software, acquisition, other generator, or lines.
// - Triggers optionally qualified by no gate, armed or running state.
// - Each of three generators drives one multipurpose line.
// - Update clock derives from sampling clock; rate is readable.
// - Update rate is capped at 125 MHz, eight nanosecond resolution.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "dpg_cfg.svh"

module dpg_top
#(
    parameter int SAMPLE_RATE_HZ = `DPG_SAMPLE_RATE_HZ,
    parameter int NUM_GEN        = 3
)
(
    input  wire logic        CLK_IN,
    input  wire logic        SYS_RST_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic        ACQ_TRIG_IN,
    input  wire logic        ACQ_ARMED_IN,
    input  wire logic        ACQ_RUNNING_IN,
    input  wire logic        MULTIPURPOSE_LINE_ZERO_IN,
    input  wire logic        MULTIPURPOSE_LINE_ONE_IN,
    input  wire logic        MULTIPURPOSE_LINE_TWO_IN,
    output logic             MULTIPURPOSE_LINE_ZERO_OUT,
    output logic             MULTIPURPOSE_LINE_ONE_OUT,
    output logic             MULTIPURPOSE_LINE_TWO_OUT,
    output logic             MULTIPURPOSE_LINE_ZERO_OE_OUT,
    output logic             MULTIPURPOSE_LINE_ONE_OE_OUT,
    output logic             MULTIPURPOSE_LINE_TWO_OE_OUT
);

    localparam int UPD_DIV  = (SAMPLE_RATE_HZ + `DPG_MAX_RATE_HZ - 1) /
                              `DPG_MAX_RATE_HZ;
    localparam int UPD_RATE = SAMPLE_RATE_HZ / UPD_DIV;
    localparam logic [31:0] UPD_RATE_WORD = UPD_RATE[31:0];
    localparam logic [7:0]  UPD_DIV_LAST  = 8'(UPD_DIV - 1);

    logic [31:0]        reg_ctrl   [NUM_GEN];
    logic [31:0]        reg_period [NUM_GEN];
    logic [31:0]        reg_high   [NUM_GEN];
    logic [31:0]        reg_delay  [NUM_GEN];
    logic [31:0]        reg_loops  [NUM_GEN];
    logic [NUM_GEN-1:0] st_running;
    logic [NUM_GEN-1:0] st_done;
    logic [NUM_GEN-1:0] gen_pulse;
    logic [NUM_GEN-1:0] sw_fire;
    logic [NUM_GEN-1:0] next_sw_fire;
    logic [7:0]         tick_cnt;
    logic               tick;

    // Bus decode
    wire        setup_phase = PSEL_IN && !PENABLE_IN;
    wire        access      = PSEL_IN && PENABLE_IN;
    wire [1:0]  chan_sel    = PADDR_IN[6:5];
    wire [2:0]  reg_sel     = PADDR_IN[4:2];
    wire        aligned     = (PADDR_IN[1:0] == 2'h0);
    wire        in_chan     = !PADDR_IN[7] && aligned &&
                              (chan_sel < 2'(NUM_GEN)) &&
                              (reg_sel <= `DPG_OFF_STATUS);
    wire        hit_swtrig  = (PADDR_IN == `DPG_ADDR_SWTRIG);
    wire        hit_rate    = (PADDR_IN == `DPG_ADDR_RATE);
    wire        mapped      = in_chan || hit_swtrig || hit_rate;
    wire        ro_hit      = hit_rate ||
                              (in_chan && (reg_sel == `DPG_OFF_STATUS));
    wire        wr_ok       = access && PWRITE_IN && mapped && !ro_hit;
    wire        wr_swtrig   = wr_ok && hit_swtrig;

    assign PREADY_OUT  = 1'b1;
    assign PSLVERR_OUT = access && (!mapped || (PWRITE_IN && ro_hit));

    // Read data mux
    logic [31:0] rd_word;
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (hit_rate)
            rd_word = UPD_RATE_WORD;
        else if (in_chan && reg_sel == `DPG_OFF_CTRL)
            rd_word = reg_ctrl[chan_sel];
        else if (in_chan && reg_sel == `DPG_OFF_PERIOD)
            rd_word = reg_period[chan_sel];
        else if (in_chan && reg_sel == `DPG_OFF_HIGH)
            rd_word = reg_high[chan_sel];
        else if (in_chan && reg_sel == `DPG_OFF_DELAY)
            rd_word = reg_delay[chan_sel];
        else if (in_chan && reg_sel == `DPG_OFF_LOOPS)
            rd_word = reg_loops[chan_sel];
        else if (in_chan && reg_sel == `DPG_OFF_STATUS)
        begin
            rd_word[`DPG_STAT_RUNNING] = st_running[chan_sel];
            rd_word[`DPG_STAT_DONE]    = st_done[chan_sel];
        end
    end

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            PRDATA_OUT <= 32'h0000_0000;
        else if (setup_phase && !PWRITE_IN)
            PRDATA_OUT <= rd_word;
    end

    // Configuration registers
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            for (int i = 0; i < NUM_GEN; i++)
            begin
                reg_ctrl[i]   <= `DPG_RST_CTRL;
                reg_period[i] <= `DPG_RST_PERIOD;
                reg_high[i]   <= `DPG_RST_HIGH;
                reg_delay[i]  <= `DPG_RST_DELAY;
                reg_loops[i]  <= `DPG_RST_LOOPS;
            end
        end
        else if (wr_ok && in_chan)
        begin
            if (reg_sel == `DPG_OFF_CTRL)
                reg_ctrl[chan_sel] <= PWDATA_IN & `DPG_CTRL_MASK;
            else if (reg_sel == `DPG_OFF_PERIOD)
                reg_period[chan_sel] <= PWDATA_IN;
            else if (reg_sel == `DPG_OFF_HIGH)
                reg_high[chan_sel] <= PWDATA_IN;
            else if (reg_sel == `DPG_OFF_DELAY)
                reg_delay[chan_sel] <= PWDATA_IN;
            else if (reg_sel == `DPG_OFF_LOOPS)
                reg_loops[chan_sel] <= PWDATA_IN;
        end
    end

    assign next_sw_fire = wr_swtrig ? PWDATA_IN[NUM_GEN-1:0] : '0;

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            sw_fire <= '0;
        else
            sw_fire <= next_sw_fire;
    end

    assign tick = (tick_cnt == UPD_DIV_LAST);

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            tick_cnt <= 8'h00;
        else if (tick)
            tick_cnt <= 8'h00;
        else
            tick_cnt <= tick_cnt + 8'h01;
    end

    // External inputs
    logic [5:0] ext_sync;
    logic [5:0] ext_prev;

    dpg_sync #(.WIDTH(6)) u_sync
    (
        .clk_in   (CLK_IN),
        .rst_in   (SYS_RST_IN),
        .async_in ({MULTIPURPOSE_LINE_TWO_IN, MULTIPURPOSE_LINE_ONE_IN,
                    MULTIPURPOSE_LINE_ZERO_IN, ACQ_RUNNING_IN,
                    ACQ_ARMED_IN, ACQ_TRIG_IN}),
        .sync_out (ext_sync)
    );

    logic [NUM_GEN-1:0] gen_prev;

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            ext_prev <= 6'h00;
            gen_prev <= '0;
        end
        else
        begin
            ext_prev <= ext_sync;
            gen_prev <= gen_pulse;
        end
    end

    wire [5:0]         ext_rise = ext_sync & ~ext_prev;
    wire [NUM_GEN-1:0] gen_rise = gen_pulse & ~gen_prev;
    wire               armed    = ext_sync[1];
    wire               running  = ext_sync[2];

    genvar g;
    generate
        for (g = 0; g < NUM_GEN; g++)
        begin : gen_ch
            localparam int OTHER = (g + NUM_GEN - 1) % NUM_GEN;

            dpg_chan_if chan_bus ();

            wire [31:0] ctrl = reg_ctrl[g];
            wire dpg_pkg::dpg_src_type src =
                dpg_pkg::dpg_src_type'(ctrl[`DPG_CTRL_SRC_HI:
                                            `DPG_CTRL_SRC_LO]);
            wire dpg_pkg::dpg_gate_type gsel =
                dpg_pkg::dpg_gate_type'(ctrl[`DPG_CTRL_GATE_HI:
                                             `DPG_CTRL_GATE_LO]);

            wire src_rise =
                (src == dpg_pkg::DPG_SRC_SOFTWARE)  ? sw_fire[g]      :
                (src == dpg_pkg::DPG_SRC_ACQ_TRIG)  ? ext_rise[0]     :
                (src == dpg_pkg::DPG_SRC_OTHER_GEN) ? gen_rise[OTHER] :
                (src == dpg_pkg::DPG_SRC_LINE_ZERO) ? ext_rise[3]     :
                (src == dpg_pkg::DPG_SRC_LINE_ONE)  ? ext_rise[4]     :
                (src == dpg_pkg::DPG_SRC_LINE_TWO)  ? ext_rise[5]     :
                1'b0;
            wire src_level =
                (src == dpg_pkg::DPG_SRC_SOFTWARE)  ? 1'b1             :
                (src == dpg_pkg::DPG_SRC_ACQ_TRIG)  ? ext_sync[0]      :
                (src == dpg_pkg::DPG_SRC_OTHER_GEN) ? gen_pulse[OTHER] :
                (src == dpg_pkg::DPG_SRC_LINE_ZERO) ? ext_sync[3]      :
                (src == dpg_pkg::DPG_SRC_LINE_ONE)  ? ext_sync[4]      :
                (src == dpg_pkg::DPG_SRC_LINE_TWO)  ? ext_sync[5]      :
                1'b0;
            wire gate_ok =
                (gsel == dpg_pkg::DPG_GATE_ARMED)   ? armed   :
                (gsel == dpg_pkg::DPG_GATE_RUNNING) ? running :
                1'b1;

            assign chan_bus.enable = ctrl[`DPG_CTRL_ENABLE];
            assign chan_bus.mode   =
                dpg_pkg::dpg_mode_type'(ctrl[`DPG_CTRL_MODE_HI:
                                             `DPG_CTRL_MODE_LO]);
            assign chan_bus.period = reg_period[g];
            assign chan_bus.high   = reg_high[g];
            assign chan_bus.delay  = reg_delay[g];
            assign chan_bus.loops  = reg_loops[g];
            assign st_running[g]   = chan_bus.running;
            assign st_done[g]      = chan_bus.done;

            dpg_chan u_chan
            (
                .clk_in    (CLK_IN),
                .rst_in    (SYS_RST_IN),
                .tick_in   (tick),
                .trig_in   (src_rise && gate_ok),
                .level_in  (src_level && gate_ok),
                .cfg       (chan_bus.gen),
                .pulse_out (gen_pulse[g])
            );
        end
    endgenerate

    assign MULTIPURPOSE_LINE_ZERO_OUT    = gen_pulse[0];
    assign MULTIPURPOSE_LINE_ONE_OUT     = gen_pulse[1];
    assign MULTIPURPOSE_LINE_TWO_OUT     = gen_pulse[2];
    assign MULTIPURPOSE_LINE_ZERO_OE_OUT = reg_ctrl[0][`DPG_CTRL_ENABLE];
    assign MULTIPURPOSE_LINE_ONE_OE_OUT  = reg_ctrl[1][`DPG_CTRL_ENABLE];
    assign MULTIPURPOSE_LINE_TWO_OE_OUT  = reg_ctrl[2][`DPG_CTRL_ENABLE];

endmodule : dpg_top

// ### hw/dpg_cfg.svh
`ifndef DPG_CFG_SVH
`define DPG_CFG_SVH

// Register map
`define DPG_OFF_CTRL        3'h0
`define DPG_OFF_PERIOD      3'h1
`define DPG_OFF_HIGH        3'h2
`define DPG_OFF_DELAY       3'h3
`define DPG_OFF_LOOPS       3'h4
`define DPG_OFF_STATUS      3'h5
`define DPG_ADDR_SWTRIG     8'h60
`define DPG_ADDR_RATE       8'h64

// Control field positions
`define DPG_CTRL_ENABLE     0
`define DPG_CTRL_MODE_LO    1
`define DPG_CTRL_MODE_HI    2
`define DPG_CTRL_SRC_LO     3
`define DPG_CTRL_SRC_HI     5
`define DPG_CTRL_GATE_LO    6
`define DPG_CTRL_GATE_HI    7
`define DPG_CTRL_MASK       32'h0000_00ff

// Status field positions
`define DPG_STAT_RUNNING    0
`define DPG_STAT_DONE       1

// Reset values
`define DPG_RST_CTRL        32'h0000_0000
`define DPG_RST_PERIOD      32'h0000_0002
`define DPG_RST_HIGH        32'h0000_0001
`define DPG_RST_DELAY       32'h0000_0000
`define DPG_RST_LOOPS       32'h0000_0001

// Timing limits
`define DPG_MIN_PERIOD      32'h0000_0002
`define DPG_MIN_HIGH        32'h0000_0001
`define DPG_MAX_RATE_HZ     125000000
`define DPG_SAMPLE_RATE_HZ  10000000

`endif

// ### hw/dpg_pkg.sv
package dpg_pkg;

    typedef enum logic [1:0]
    {
        DPG_MODE_SINGLE,
        DPG_MODE_REPEAT,
        DPG_MODE_GATED
    } dpg_mode_type;

    typedef enum logic [2:0]
    {
        DPG_SRC_SOFTWARE,
        DPG_SRC_ACQ_TRIG,
        DPG_SRC_OTHER_GEN,
        DPG_SRC_LINE_ZERO,
        DPG_SRC_LINE_ONE,
        DPG_SRC_LINE_TWO
    } dpg_src_type;

    typedef enum logic [1:0]
    {
        DPG_GATE_NONE,
        DPG_GATE_ARMED,
        DPG_GATE_RUNNING
    } dpg_gate_type;

    typedef enum logic [1:0]
    {
        DPG_ST_IDLE,
        DPG_ST_WAIT,
        DPG_ST_RUN,
        DPG_ST_DONE
    } dpg_state_type;

endpackage : dpg_pkg

// ### hw/dpg_chan_if.sv
`timescale 1ns/10ps

interface dpg_chan_if;
    logic                  enable;
    dpg_pkg::dpg_mode_type mode;
    logic [31:0]           period;
    logic [31:0]           high;
    logic [31:0]           delay;
    logic [31:0]           loops;
    logic                  running;
    logic                  done;

    modport ctl
    (
        output enable,
        output mode,
        output period,
        output high,
        output delay,
        output loops,
        input  running,
        input  done
    );

    modport gen
    (
        input  enable,
        input  mode,
        input  period,
        input  high,
        input  delay,
        input  loops,
        output running,
        output done
    );
endinterface : dpg_chan_if

// ### hw/dpg_sync.sv
`timescale 1ns/10ps

module dpg_sync
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            stage_one <= '0;
            sync_out  <= '0;
        end
        else
        begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule : dpg_sync

// ### hw/dpg_chan.sv
`timescale 1ns/10ps
`include "dpg_cfg.svh"

module dpg_chan
(
    input  wire logic  clk_in,
    input  wire logic  rst_in,
    input  wire logic  tick_in,
    input  wire logic  trig_in,
    input  wire logic  level_in,
    dpg_chan_if.gen    cfg,
    output logic       pulse_out
);

    dpg_pkg::dpg_state_type state;
    dpg_pkg::dpg_state_type next_state;
    logic [31:0]            cnt;
    logic [31:0]            next_cnt;
    logic [31:0]            loop_cnt;
    logic [31:0]            next_loop_cnt;
    logic                   next_pulse;
    logic [31:0]            eff_period;
    logic [31:0]            eff_high;
    logic                   gated;
    logic                   start;
    logic                   last_loop;

    assign eff_period = (cfg.period < `DPG_MIN_PERIOD) ? `DPG_MIN_PERIOD
                                                        : cfg.period;
    assign eff_high   = (cfg.high < `DPG_MIN_HIGH) ? `DPG_MIN_HIGH
                                                    : cfg.high;
    assign gated      = (cfg.mode == dpg_pkg::DPG_MODE_GATED);
    assign start      = gated ? level_in : trig_in;
    assign last_loop  = (cfg.loops != 32'h0000_0000) &&
                        (loop_cnt == cfg.loops - 32'h0000_0001);

    always_comb
    begin
        next_state    = state;
        next_cnt      = cnt;
        next_loop_cnt = loop_cnt;
        if (!cfg.enable)
        begin
            next_state    = dpg_pkg::DPG_ST_IDLE;
            next_cnt      = 32'h0000_0000;
            next_loop_cnt = 32'h0000_0000;
        end
        else
        begin
            case (state)
                dpg_pkg::DPG_ST_IDLE:
                begin
                    if (start)
                    begin
                        next_cnt      = 32'h0000_0000;
                        next_loop_cnt = 32'h0000_0000;
                        if (cfg.delay == 32'h0000_0000)
                            next_state = dpg_pkg::DPG_ST_RUN;
                        else
                            next_state = dpg_pkg::DPG_ST_WAIT;
                    end
                end
                dpg_pkg::DPG_ST_WAIT:
                begin
                    if (tick_in)
                    begin
                        if (cnt == cfg.delay - 32'h0000_0001)
                        begin
                            next_state = dpg_pkg::DPG_ST_RUN;
                            next_cnt   = 32'h0000_0000;
                        end
                        else
                            next_cnt = cnt + 32'h0000_0001;
                    end
                end
                dpg_pkg::DPG_ST_RUN:
                begin
                    if (tick_in)
                    begin
                        if (cnt == eff_period - 32'h0000_0001)
                        begin
                            next_cnt = 32'h0000_0000;
                            if (last_loop)
                            begin
                                if (cfg.mode == dpg_pkg::DPG_MODE_REPEAT)
                                    next_state = dpg_pkg::DPG_ST_IDLE;
                                else
                                    next_state = dpg_pkg::DPG_ST_DONE;
                            end
                            else
                                next_loop_cnt = loop_cnt + 32'h0000_0001;
                        end
                        else
                            next_cnt = cnt + 32'h0000_0001;
                    end
                end
                default:
                begin
                    next_state = dpg_pkg::DPG_ST_DONE;
                end
            endcase
            if (gated && !level_in)
                next_state = dpg_pkg::DPG_ST_IDLE;
        end
        next_pulse = (next_state == dpg_pkg::DPG_ST_RUN) &&
                     (next_cnt < eff_high);
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state     <= dpg_pkg::DPG_ST_IDLE;
            cnt       <= 32'h0000_0000;
            loop_cnt  <= 32'h0000_0000;
            pulse_out <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            cnt       <= next_cnt;
            loop_cnt  <= next_loop_cnt;
            pulse_out <= next_pulse;
        end
    end

    assign cfg.running = (state == dpg_pkg::DPG_ST_WAIT) ||
                         (state == dpg_pkg::DPG_ST_RUN);
    assign cfg.done    = (state == dpg_pkg::DPG_ST_DONE);

endmodule : dpg_chan

// ### dv/dpg_top_chk.sv
`timescale 1ns/10ps

module dpg_top_chk
#(
    parameter int SAMPLE_RATE_HZ = 10000000
)
(
    input wire logic        CLK_IN,
    input wire logic        SYS_RST_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [7:0]  PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        PREADY_OUT,
    input wire logic        PSLVERR_OUT,
    input wire logic        MULTIPURPOSE_LINE_ZERO_OUT,
    input wire logic        MULTIPURPOSE_LINE_ONE_OUT,
    input wire logic        MULTIPURPOSE_LINE_ZERO_OE_OUT,
    input wire logic        MULTIPURPOSE_LINE_ONE_OE_OUT
);
    localparam int DIV  = (SAMPLE_RATE_HZ + 124999999) / 125000000;
    localparam int RATE = SAMPLE_RATE_HZ / DIV;

    wire acc = PSEL_IN && PENABLE_IN;
    wire en0 = acc && PWRITE_IN && PADDR_IN == 8'h00 && PWDATA_IN[0];

    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    property p_ready; PREADY_OUT; endproperty
    a_ready: assert property (p_ready)
        else $error("ready low");
    property p_low0;
        !MULTIPURPOSE_LINE_ZERO_OE_OUT [*2] |-> !MULTIPURPOSE_LINE_ZERO_OUT;
    endproperty
    a_low0: assert property (p_low0)
        else $error("line zero high while off");
    property p_low1;
        !MULTIPURPOSE_LINE_ONE_OE_OUT [*2] |-> !MULTIPURPOSE_LINE_ONE_OUT;
    endproperty
    a_low1: assert property (p_low1)
        else $error("line one high while off");
    property p_oe_rise;
        $rose(MULTIPURPOSE_LINE_ZERO_OE_OUT) |-> $past(en0);
    endproperty
    a_oe_rise: assert property (p_oe_rise)
        else $error("line zero enabled without write");
    property p_err_phase; PSLVERR_OUT |-> acc; endproperty
    a_err_phase: assert property (p_err_phase)
        else $error("error outside access");
    property p_unmapped; acc && PADDR_IN >= 8'h68 |-> PSLVERR_OUT; endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access accepted");
    property p_misalign; acc && PADDR_IN[1:0] != 2'h0 |-> PSLVERR_OUT;
    endproperty
    a_misalign: assert property (p_misalign)
        else $error("misaligned access accepted");
    property p_rate_ro; acc && PWRITE_IN && PADDR_IN == 8'h64 |-> PSLVERR_OUT;
    endproperty
    a_rate_ro: assert property (p_rate_ro)
        else $error("rate write accepted");
    property p_rate_val;
        acc && !PWRITE_IN && PADDR_IN == 8'h64
            |-> PRDATA_OUT == 32'(RATE) && !PSLVERR_OUT;
    endproperty
    a_rate_val: assert property (p_rate_val)
        else $error("rate readback wrong");

    c_line0: cover property ($rose(MULTIPURPOSE_LINE_ZERO_OUT));
    c_line1: cover property ($rose(MULTIPURPOSE_LINE_ONE_OUT));
    c_err: cover property (PSLVERR_OUT);
endmodule : dpg_top_chk

bind dpg_top dpg_top_chk #(.SAMPLE_RATE_HZ(SAMPLE_RATE_HZ)) u_chk
(
    .CLK_IN, .SYS_RST_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN,
    .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT,
    .MULTIPURPOSE_LINE_ZERO_OUT, .MULTIPURPOSE_LINE_ONE_OUT,
    .MULTIPURPOSE_LINE_ZERO_OE_OUT, .MULTIPURPOSE_LINE_ONE_OE_OUT
);

// ### dv/dpg_ext_equip.sv
`timescale 1ns/10ps

module dpg_ext_equip
(
    input  wire logic [2:0] line_in,
    input  wire logic       clk_in,
    output logic      [2:0] drive_low_out
);
    int         rises [3];
    logic [2:0] prev = 3'h0;

    initial drive_low_out = 3'h0;

    always @(posedge clk_in)
    begin
        for (int i = 0; i < 3; i++)
            if (line_in[i] && !prev[i])
                rises[i]++;
        prev <= line_in;
    end

    // Pulls a line low for four cycles
    task automatic strobe(input int n);
        @(posedge clk_in);
        drive_low_out[n] <= 1'b1;
        repeat (4) @(posedge clk_in);
        drive_low_out[n] <= 1'b0;
    endtask : strobe
endmodule : dpg_ext_equip

// ### dv/digital_pulse_generator_tb.sv
`timescale 1ns/10ps

module digital_pulse_generator_tb;
    typedef struct { int ch, per, hi, dly, lp, ef, eh, er; } dpg_row_type;

    logic        clk, rst, psel, pen, pwr, acq_trig, acq_armed, acq_run;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic        pready, pslverr, erv;
    logic [2:0]  line_in, line_out, line_oe, drive_low;
    int          mismatches, n_compared, f, hs, rs, cyc, n2;
    int          srcs [4] = '{1, 3, 5, 2};
    dpg_row_type rows [5] = '{'{0, 2, 1, 0, 1, 2, 1, 1},
        '{1, 3, 1, 0, 2, 2, 2, 2}, '{2, 5, 2, 3, 3, 5, 6, 3},
        '{0, 4, 3, 1, 1, 3, 3, 1}, '{1, 3, 3, 0, 2, 2, 6, 1}};

    // Released line floats high
    assign line_in = (line_oe & line_out) | (~line_oe & ~drive_low);

    dpg_top DUT
    (
        .CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .ACQ_TRIG_IN(acq_trig), .ACQ_ARMED_IN(acq_armed),
        .ACQ_RUNNING_IN(acq_run),
        .MULTIPURPOSE_LINE_ZERO_IN(line_in[0]),
        .MULTIPURPOSE_LINE_ONE_IN(line_in[1]),
        .MULTIPURPOSE_LINE_TWO_IN(line_in[2]),
        .MULTIPURPOSE_LINE_ZERO_OUT(line_out[0]),
        .MULTIPURPOSE_LINE_ONE_OUT(line_out[1]),
        .MULTIPURPOSE_LINE_TWO_OUT(line_out[2]),
        .MULTIPURPOSE_LINE_ZERO_OE_OUT(line_oe[0]),
        .MULTIPURPOSE_LINE_ONE_OE_OUT(line_oe[1]),
        .MULTIPURPOSE_LINE_TWO_OE_OUT(line_oe[2])
    );

    dpg_ext_equip ext
    (
        .line_in(line_in),
        .clk_in(clk),
        .drive_low_out(drive_low)
    );

    task automatic tally_and_finish;
        if (mismatches == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        {psel, pen} <= 2'b00;
    endtask : apb

    function automatic logic [31:0] ctl(input int m, input int s, input int g);
        return {24'h0, 2'(g), 3'(s), 2'(m), 1'b1};
    endfunction : ctl

    task automatic cfg(input int ch, input int p, input int h, input int dl,
                       input int lp, input logic [31:0] c);
        logic [31:0] v [6];
        v = '{32'h0, 32'(p), 32'(h), 32'(dl), 32'(lp), c};
        foreach (v[i])
            apb(1'b1, 8'(ch * 32 + i % 5 * 4), v[i]);
    endtask : cfg

    task automatic measure(input int ch, input int len);
        logic p;
        logic hi;
        p = 1'b0;
        f = 0;
        hs = 0;
        rs = 0;
        for (int k = 1; k <= len; k++)
        begin
            @(posedge clk);
            hi = (line_out[ch] === 1'b1);
            if (hi && f == 0)
                f = k;
            hs += hi;
            rs += hi && !p;
            p = hi;
        end
    endtask : measure

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
        if (++cyc == 5000)
        begin
            mismatches++;
            tally_and_finish();
        end

    initial
    begin
        {rst, psel, pen, pwr, acq_trig, acq_armed, acq_run} = 7'h40;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 8'h24, 32'h0);
        check(rdv, 32'h2);
        apb(1'b0, 8'h28, 32'h0);
        check(rdv, 32'h1);
        apb(1'b0, 8'h2c, 32'h0);
        check(rdv, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        check(rdv, 32'h1);
        apb(1'b0, 8'h64, 32'h0);
        check(rdv, 32'd10000000);
        check(32'(rdv <= 32'd125000000), 32'h1);
        apb(1'b1, 8'h64, 32'h5);
        check(erv, 1'b1);
        apb(1'b0, 8'h68, 32'h0);
        check(erv, 1'b1);
        apb(1'b0, 8'h02, 32'h0);
        check(erv, 1'b1);
        foreach (rows[i])
        begin
            cfg(rows[i].ch, rows[i].per, rows[i].hi, rows[i].dly, rows[i].lp,
                ctl(0, 0, 0));
            apb(1'b1, 8'h60, 32'(1 << rows[i].ch));
            measure(rows[i].ch, rows[i].dly + rows[i].per * rows[i].lp + 6);
            check(f, rows[i].ef);
            check(hs, rows[i].eh);
            check(rs, rows[i].er);
        end
        apb(1'b1, 8'h60, 32'h2);
        measure(1, 12);
        check(rs, 0);
        apb(1'b0, 8'h34, 32'h0);
        check(rdv, 32'h2);
        cfg(0, 2, 1, 0, 2, ctl(1, 0, 0));
        repeat (2)
        begin
            apb(1'b1, 8'h60, 32'h1);
            measure(0, 8);
            check(rs, 2);
        end
        cfg(0, 4, 2, 0, 0, ctl(1, 0, 0));
        apb(1'b1, 8'h60, 32'h1);
        measure(0, 40);
        check(rs, 10);
        check(hs, 20);
        apb(1'b1, 8'h00, 32'h0);
        measure(0, 10);
        check(hs, 0);
        check(line_oe[0], 1'b0);
        apb(1'b1, 8'h40, 32'h0);
        foreach (srcs[i])
        begin
            cfg(1, 3, 1, 0, 2, ctl(0, srcs[i], 0));
            if (srcs[i] == 1)
                acq_trig <= 1'b1;
            else if (srcs[i] == 2)
            begin
                cfg(0, 2, 1, 0, 1, ctl(0, 0, 0));
                apb(1'b1, 8'h60, 32'h1);
            end
            else
                ext.strobe(srcs[i] - 3);
            measure(1, 24);
            acq_trig <= 1'b0;
            check(rs, 2);
        end
        for (int g = 1; g < 3; g++)
        begin
            cfg(1, 2, 1, 0, 1, ctl(0, 0, g));
            for (int lv = 0; lv < 2; lv++)
            begin
                acq_armed <= (g == 1) && lv;
                acq_run <= (g == 2) && lv;
                repeat (4) @(posedge clk);
                apb(1'b1, 8'h60, 32'h2);
                measure(1, 6);
                check(rs, lv);
            end
        end
        n2 = ext.rises[2];
        cfg(2, 2, 1, 0, 0, ctl(2, 0, 2));
        measure(2, 20);
        check(32'(rs >= 8), 32'h1);
        check(32'(ext.rises[2] - n2 >= 8), 32'h1);
        acq_run <= 1'b0;
        repeat (5) @(posedge clk);
        measure(2, 10);
        check(hs, 0);
        tally_and_finish();
    end
endmodule : digital_pulse_generator_tb
